/* ppk_consts.svh */
/*
  Constants of the paging panel key logic: key indices, timing figures,
  derived cycle counts, register offsets and reset values.
  Assumes a 100 MHz system clock and a plain register port.
*/
// Notes on behaviour
// - Up to 50 selection keys, count set by model, each with a lamp.
// - Selection key press toggles its area; lamp follows the selection.
// - Default mapping: selection key n picks area n.
// - Every-area key selects all programmed areas; next press clears them.
// - Chime key starts chime to selection; lamp lit meanwhile; halt aborts.
// - In setup, chime key leaves setup back to normal operation.
// - Message key starts stored message; lamp lit meanwhile; halt aborts.
// - In setup, message key decrements the selected parameter value.
// - Announcement lasts only while speak key held; busy lamp steady then.
// - Busy lamp flashes on busy area or preemption; no automatic resume.
// - Power key toggles power; lamp flashes while booting, steady when ready.
// - Power off needs the power key held at least one second.
// - A configuration bit can disable the power key outside setup.
// - In setup, power key selects the previous parameter.
// - Halt aborts alarm or message; second emergency press ends alarm.
// - Stop ends only own events, unless this is the directing console.
// - In setup, halt key increments the selected parameter value.
// - Music key enters assign mode; selection keys assign background music.
// - Halt pressed while music key held enters setup; music lamp flashes.
// - In setup, music key selects the next parameter.
// - Emergency key starts alarm to all areas; alarm lamp lit meanwhile.
// - Status display holds two lines of sixteen characters.
// - Assign mode ends after fifteen seconds or any function key press.
`ifndef PPK_CONSTS_SVH
`define PPK_CONSTS_SVH

// ----------------------------------------------------------------------
// Keys and panel sizes
// ----------------------------------------------------------------------
`define PPK_NUM_SEL 50
`define PPK_NUM_KEYS 58
`define PPK_K_EVERY 50
`define PPK_K_CHIME 51
`define PPK_K_MSG 52
`define PPK_K_SPEAK 53
`define PPK_K_POWER 54
`define PPK_K_HALT 55
`define PPK_K_MUSIC 56
`define PPK_K_EMERG 57
`define PPK_NUM_PARAMS 8
`define PPK_DISP_CHARS 32

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPK_CLK_HZ 100000000
`define PPK_DEB_MS 5
`define PPK_HOLD_MS 1000
`define PPK_ASSIGN_MS 15000
`define PPK_BLINK_MS 250
`define PPK_DEB_CYC (`PPK_DEB_MS * (`PPK_CLK_HZ / 1000))
`define PPK_HOLD_CYC (`PPK_HOLD_MS * (`PPK_CLK_HZ / 1000))
`define PPK_ASSIGN_CYC (`PPK_ASSIGN_MS * (`PPK_CLK_HZ / 1000))
`define PPK_BLINK_CYC (`PPK_BLINK_MS * (`PPK_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define PPK_REG_CTRL 8'h00
`define PPK_REG_STATUS 8'h04
`define PPK_REG_PARAM 8'h08
`define PPK_REG_SEL_LO 8'h10
`define PPK_REG_SEL_HI 8'h14
`define PPK_REG_MUS_LO 8'h18
`define PPK_REG_MUS_HI 8'h1C
`define PPK_DISP_BASE 3'h4
`define PPK_CTRL_PWR_EN_RST 1'b1
`define PPK_CTRL_DIRECT_RST 1'b0
`define PPK_CTRL_COUNT_RST 6'h32

`endif

/* ppk_pkg.sv */
/*
  Types of the paging panel key logic: modes, key vector, central unit
  request and status bundles, lamp bundle and the block state.
  Assumes ppk_consts.svh is on the include path.
*/
`include "ppk_consts.svh"

package ppk_pkg;

  // Operating modes, one-hot
  typedef enum logic [2:0] {
    PPK_NORMAL = 3'b001,
    PPK_ASSIGN = 3'b010,
    PPK_SETUP = 3'b100
  } ppk_mode_t;

  // Raw key pins; bit order matches the key index constants
  typedef struct packed {
    logic emergency;
    logic music;
    logic halt;
    logic power;
    logic speak;
    logic msg;
    logic chime;
    logic every;
    logic [`PPK_NUM_SEL-1:0] sel;
  } ppk_keys_t;

  // Requests to the central unit
  typedef struct packed {
    logic [`PPK_NUM_SEL-1:0] areas;
    logic [`PPK_NUM_SEL-1:0] music_areas;
    logic speak;
    logic chime_start;
    logic msg_start;
    logic alarm_start;
    logic stop;
    logic stop_any;
    logic power;
  } ppk_cu_req_t;

  // Status reported by the central unit
  typedef struct packed {
    logic [`PPK_NUM_SEL-1:0] area_busy;
    logic preempt;
    logic chime_run;
    logic msg_run;
    logic alarm_run;
    logic ready;
  } ppk_cu_stat_t;

  // Panel indicators
  typedef struct packed {
    logic [`PPK_NUM_SEL-1:0] area;
    logic every;
    logic chime;
    logic msg;
    logic busy;
    logic power;
    logic music;
    logic alarm;
  } ppk_lamps_t;

  // Whole state of the key logic
  typedef struct packed {
    ppk_mode_t mode;
    logic [`PPK_NUM_KEYS-1:0] sync1;
    logic [`PPK_NUM_KEYS-1:0] sync2;
    logic [`PPK_NUM_KEYS-1:0] samp;
    logic [`PPK_NUM_KEYS-1:0] stable;
    logic [`PPK_NUM_KEYS-1:0] stable_d;
    logic [31:0] deb_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [`PPK_NUM_SEL-1:0] sel;
    logic [`PPK_NUM_SEL-1:0] music;
    logic every_on;
    logic power_en;
    logic directing;
    logic [5:0] key_count;
    logic power_on;
    logic [31:0] hold_cnt;
    logic hold_lock;
    logic speak_on;
    logic interrupted;
    logic [2:0] own;
    logic [2:0] run_d;
    logic [31:0] assign_cnt;
    logic [2:0] pidx;
    logic [8*`PPK_NUM_PARAMS-1:0] pval;
    logic [8*`PPK_DISP_CHARS-1:0] disp;
    logic [4:0] scan;
    ppk_cu_req_t req;
    ppk_lamps_t lamps;
    logic [31:0] rdata;
    logic [4:0] disp_addr;
    logic [7:0] disp_char;
  } ppk_state_t;

endpackage : ppk_pkg

/* ppk_key_logic.sv */
/*
  Paging panel key logic: debounces the panel keys, interprets them in
  normal, assign and setup modes, drives the lamps, the display scan and
  the request bundle to the central unit.
  Assumes key pins are asynchronous; central unit status and the register
  port are on the same clock.
*/
`timescale 1ns/1ps
`include "ppk_consts.svh"

module ppk_key_logic #(
  parameter int unsigned DEB_CYC = `PPK_DEB_CYC,
  parameter int unsigned HOLD_CYC = `PPK_HOLD_CYC,
  parameter int unsigned ASSIGN_CYC = `PPK_ASSIGN_CYC,
  parameter int unsigned BLINK_CYC = `PPK_BLINK_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Panel keys, raw pins
  input wire ppk_pkg::ppk_keys_t keys,
  // Central unit
  input wire ppk_pkg::ppk_cu_stat_t cu_stat,
  output ppk_pkg::ppk_cu_req_t cu_req,
  // Panel lamps and display
  output ppk_pkg::ppk_lamps_t lamps,
  output logic [4:0] disp_addr,
  output logic [7:0] disp_char,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import ppk_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Areas that exist on this model: keys at or above the count are absent
  function automatic logic [`PPK_NUM_SEL-1:0] area_mask(
    input logic [5:0] cnt
  );
    logic [`PPK_NUM_SEL-1:0] m;
    m = '0;
    for (int i = 0; i < `PPK_NUM_SEL; i++)
    begin
      m[i] = (6'(i) < cnt);
    end
    return m;
  endfunction

  ppk_state_t r;
  ppk_state_t n;
  logic [`PPK_NUM_KEYS-1:0] press;
  logic [`PPK_NUM_KEYS-1:0] held;
  logic [`PPK_NUM_SEL-1:0] mask;
  logic fn_press;
  logic stop_ok;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // All decisions work on debounced levels and one-cycle press edges
  always_comb
  begin
    n = r;
    held = r.stable;
    press = r.stable & ~r.stable_d;
    mask = area_mask(r.key_count);
    fn_press = |press[`PPK_K_EMERG:`PPK_K_EVERY];
    stop_ok = r.directing | (|r.own);

    // Pulses last a single cycle
    n.req.chime_start = 1'b0;
    n.req.msg_start = 1'b0;
    n.req.alarm_start = 1'b0;
    n.req.stop = 1'b0;
    n.rdata = 32'h0;

    // Two-stage synchroniser; only sync2 is looked at
    n.sync1 = keys;
    n.sync2 = r.sync1;
    n.stable_d = r.stable;

    if (r.deb_cnt >= DEB_CYC - 1)
    begin
      // A level counts once two samples one tick apart agree
      n.deb_cnt = 32'h0;
      n.samp = r.sync2;
      n.stable = (r.stable & (r.samp ^ r.sync2)) |
                 (r.sync2 & ~(r.samp ^ r.sync2));
    end
    else
    begin
      n.deb_cnt = r.deb_cnt + 32'h1;
    end

    // Shared flash clock for all blinking lamps
    if (r.blink_cnt >= BLINK_CYC - 1)
    begin
      n.blink_cnt = 32'h0;
      n.blink = ~r.blink;
    end
    else
    begin
      n.blink_cnt = r.blink_cnt + 32'h1;
    end

    // Own-event tracking ends when the central unit drops the event
    n.run_d = {cu_stat.alarm_run, cu_stat.msg_run, cu_stat.chime_run};
    n.own = r.own & ~(r.run_d & ~n.run_d);

    // Display scan walks the two lines of sixteen characters
    // display
    n.scan = r.scan + 5'h1;
    n.disp_addr = r.scan;
    n.disp_char = r.disp[{r.scan, 3'b000} +: 8];

    case (r.mode)
      PPK_SETUP:
      begin
        if (press[`PPK_K_CHIME])
          n.mode = PPK_NORMAL;
        if (press[`PPK_K_MSG])
          n.pval[{r.pidx, 3'b000} +: 8] = r.pval[{r.pidx, 3'b000} +: 8] -
                                          8'h01;
        if (press[`PPK_K_HALT])
          n.pval[{r.pidx, 3'b000} +: 8] = r.pval[{r.pidx, 3'b000} +: 8] +
                                          8'h01;
        if (press[`PPK_K_POWER])
          n.pidx = r.pidx - 3'h1;
        if (press[`PPK_K_MUSIC])
          n.pidx = r.pidx + 3'h1;
      end
      PPK_ASSIGN:
      begin
        n.assign_cnt = r.assign_cnt + 32'h1;
        if (press[`PPK_K_HALT] && held[`PPK_K_MUSIC])
          n.mode = PPK_SETUP;
        else if (fn_press || r.assign_cnt >= ASSIGN_CYC - 1)
          n.mode = PPK_NORMAL;
        n.music = r.music ^ (press[`PPK_NUM_SEL-1:0] & mask);
      end
      PPK_NORMAL:
      begin
        if (press[`PPK_K_HALT] && held[`PPK_K_MUSIC])
          n.mode = PPK_SETUP;
        else if (press[`PPK_K_MUSIC])
        begin
          n.mode = PPK_ASSIGN;
          n.assign_cnt = 32'h0;
        end
        // toggle selection; absent keys ignored; key n area n
        n.sel = r.sel ^ (press[`PPK_NUM_SEL-1:0] & mask);
        if (press[`PPK_K_EVERY])
        begin
          n.every_on = ~r.every_on;
          n.sel = r.every_on ? '0 : mask;
        end
        if (press[`PPK_K_CHIME] && |r.sel)
        begin
          n.req.chime_start = 1'b1;
          n.own[0] = 1'b1;
        end
        if (press[`PPK_K_MSG] && |r.sel)
        begin
          n.req.msg_start = 1'b1;
          n.own[1] = 1'b1;
        end
        if (press[`PPK_K_HALT] && !held[`PPK_K_MUSIC] && stop_ok)
        begin
          n.req.stop = 1'b1;
          n.own = 3'b000;
        end
      end
      default:
        n.mode = PPK_NORMAL;
    endcase

    // alarm start; second press ends it
    if (press[`PPK_K_EMERG])
    begin
      if (cu_stat.alarm_run && (r.own[2] || r.directing))
      begin
        n.req.stop = 1'b1;
        n.own[2] = 1'b0;
      end
      else if (!cu_stat.alarm_run)
      begin
        n.req.alarm_start = 1'b1;
        n.own[2] = 1'b1;
      end
    end

    // speak while held; no resume after preemption
    if (!held[`PPK_K_SPEAK])
    begin
      n.speak_on = 1'b0;
      n.interrupted = 1'b0;
    end
    else if (r.speak_on && cu_stat.preempt)
    begin
      n.speak_on = 1'b0;
      n.interrupted = 1'b1;
    end
    else if (press[`PPK_K_SPEAK] && r.mode != PPK_SETUP && |r.sel &&
             !(|(r.sel & cu_stat.area_busy)))
    begin
      n.speak_on = 1'b1;
    end

    // power key disable; toggle on; one second hold to turn off
    if (!held[`PPK_K_POWER])
    begin
      n.hold_cnt = 32'h0;
      n.hold_lock = 1'b0;
    end
    else if (r.mode != PPK_SETUP && r.power_en)
    begin
      if (press[`PPK_K_POWER] && !r.power_on)
      begin
        // The press that powers up must not also power down
        n.power_on = 1'b1;
        n.hold_lock = 1'b1;
      end
      else if (r.power_on && !r.hold_lock)
      begin
        n.hold_cnt = r.hold_cnt + 32'h1;
        if (r.hold_cnt >= HOLD_CYC - 1)
        begin
          n.power_on = 1'b0;
          n.hold_lock = 1'b1;
        end
      end
    end

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `PPK_REG_CTRL:
        begin
          n.power_en = reg_wdata[0];
          n.directing = reg_wdata[1];
          n.key_count = (reg_wdata[13:8] > 6'(`PPK_NUM_SEL)) ?
                        6'(`PPK_NUM_SEL) : reg_wdata[13:8];
        end
        `PPK_REG_PARAM:
        begin
          n.pidx = reg_wdata[10:8];
          n.pval[{reg_wdata[10:8], 3'b000} +: 8] = reg_wdata[7:0];
        end
        default:
        begin
          if (reg_addr[7:5] == `PPK_DISP_BASE)
            n.disp[{reg_addr[4:0], 3'b000} +: 8] = reg_wdata[7:0];
        end
      endcase
    end

    // Register reads, answered in the following cycle only
    if (reg_rd)
    begin
      case (reg_addr)
        `PPK_REG_CTRL:
          n.rdata = {18'h0, r.key_count, 6'h0, r.directing, r.power_en};
        `PPK_REG_STATUS:
          n.rdata = {13'h0, r.pidx, r.own, r.interrupted, r.speak_on,
                     r.power_on, r.every_on, 6'h0, r.mode};
        `PPK_REG_PARAM:
          n.rdata = {21'h0, r.pidx, r.pval[{r.pidx, 3'b000} +: 8]};
        `PPK_REG_SEL_LO:
          n.rdata = r.sel[31:0];
        `PPK_REG_SEL_HI:
          n.rdata = {14'h0, r.sel[`PPK_NUM_SEL-1:32]};
        `PPK_REG_MUS_LO:
          n.rdata = r.music[31:0];
        `PPK_REG_MUS_HI:
          n.rdata = {14'h0, r.music[`PPK_NUM_SEL-1:32]};
        default:
        begin
          if (reg_addr[7:5] == `PPK_DISP_BASE)
            n.rdata = {24'h0, r.disp[{reg_addr[4:0], 3'b000} +: 8]};
        end
      endcase
    end

    // Requests that stand as levels
    n.req.areas = r.sel;
    n.req.music_areas = r.music;
    n.req.speak = r.speak_on;
    n.req.power = r.power_on;
    n.req.stop_any = r.directing;

    // Area lamps show the music pattern while assigning
    n.lamps.area = (r.mode == PPK_ASSIGN) ? r.music : r.sel;
    n.lamps.every = r.every_on;
    n.lamps.chime = cu_stat.chime_run;
    n.lamps.msg = cu_stat.msg_run;
    n.lamps.alarm = cu_stat.alarm_run;
    n.lamps.busy = r.speak_on | ((r.interrupted |
                   (|(r.sel & cu_stat.area_busy))) & r.blink);
    n.lamps.power = r.power_on & (cu_stat.ready | r.blink);
    n.lamps.music = (r.mode == PPK_ASSIGN) |
                    ((r.mode == PPK_SETUP) & r.blink);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset; every field takes a constant
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r <= '0;
      r.mode <= PPK_NORMAL;
      r.power_en <= `PPK_CTRL_PWR_EN_RST;
      r.directing <= `PPK_CTRL_DIRECT_RST;
      r.key_count <= `PPK_CTRL_COUNT_RST;
      r.disp <= {`PPK_DISP_CHARS{8'h20}};
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------------------------------------
  assign cu_req = r.req;
  assign lamps = r.lamps;
  assign disp_addr = r.disp_addr;
  assign disp_char = r.disp_char;
  assign reg_rdata = r.rdata;

endmodule // ppk_key_logic

/* ppk_key_logic_assertions.sv */
/*
  Port checker of the paging panel key logic.
  Assumes it is bound into ppk_key_logic with the same hold count.
*/
`timescale 1ns/1ps
module ppk_chk #(
  parameter int unsigned HOLD_CYC = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Keys and central unit
  input wire ppk_pkg::ppk_keys_t keys,
  input wire ppk_pkg::ppk_cu_stat_t cu_stat,
  input wire ppk_pkg::ppk_cu_req_t cu_req,
  // Panel
  input wire ppk_pkg::ppk_lamps_t lamps,
  input wire logic [4:0] disp_addr
);
  import ppk_pkg::*;

  // Raw power key hold time; saturates so a stuck key cannot wrap
  logic [31:0] held_reg;
  always_ff @(posedge clock)
  begin
    if (rst || !keys.power)
      held_reg <= 32'h0;
    else if (held_reg != 32'hFFFFFFFF)
      held_reg <= held_reg + 32'h1;
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  chime_sel_a:
    assert property (cu_req.chime_start |-> cu_req.areas != '0)
    else $error("chime started with empty selection");
  msg_sel_a:
    assert property (cu_req.msg_start |-> cu_req.areas != '0)
    else $error("message started with empty selection");
  speak_sel_a:
    assert property ($rose(cu_req.speak) |-> cu_req.areas != '0)
    else $error("speech started with empty selection");
  speak_key_a:
    assert property ($fell(keys.speak) |-> ##[1:16] !cu_req.speak)
    else $error("speech outlived the speak key");
  busy_steady_a:
    assert property (cu_req.speak [*3] |-> lamps.busy)
    else $error("busy lamp dark during speech");
  chime_lamp_a:
    assert property (cu_stat.chime_run [*3] |-> lamps.chime)
    else $error("chime lamp dark while chime runs");
  alarm_lamp_a:
    assert property (cu_stat.alarm_run [*3] |-> lamps.alarm)
    else $error("alarm lamp dark while alarm runs");
  power_hold_a:
    assert property ($fell(cu_req.power) |-> held_reg >= HOLD_CYC)
    else $error("power dropped after a short press");
  stop_pulse_a:
    assert property (cu_req.stop |=> !cu_req.stop)
    else $error("stop request longer than one cycle");
  disp_scan_a:
    assert property ((!$past(rst) && !$past(rst, 2)) |->
      disp_addr == $past(disp_addr) + 5'h1)
    else $error("display scan skipped a character");
endmodule // ppk_chk

/* ppk_cu_model.sv */
/*
  Central unit model: runs chime, message and alarm for a fixed time,
  ends them on stop, boots after a power request.
  Assumes the bench drives busy areas and preemption.
*/
`timescale 1ns/1ps
module ppk_cu_model #(
  parameter int RUN = 400,
  parameter int BOOT = 200
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Console link
  input wire ppk_pkg::ppk_cu_req_t cu_req,
  output ppk_pkg::ppk_cu_stat_t cu_stat,
  // Bench controls
  input wire logic [49:0] busy_in,
  input wire logic preempt_in
);
  import ppk_pkg::*;
  int t [3];
  int boot;

  // Event timers; boot delay restarts whenever power is dropped
  always_ff @(posedge clock)
  begin
    boot <= (rst || !cu_req.power) ? BOOT : (boot > 0 ? boot - 1 : 0);
    if (rst || cu_req.stop)
      t <= '{0, 0, 0};
    else
    begin
      t[0] <= cu_req.chime_start ? RUN : (t[0] > 0 ? t[0] - 1 : 0);
      t[1] <= cu_req.msg_start ? RUN : (t[1] > 0 ? t[1] - 1 : 0);
      if (cu_req.alarm_start)
        t[2] <= t[2] > 0 ? 0 : RUN;
      else
        t[2] <= t[2] > 0 ? t[2] - 1 : 0;
    end
  end

  // Status back to the console
  assign cu_stat = '{area_busy: busy_in, preempt: preempt_in,
    chime_run: t[0] > 0, msg_run: t[1] > 0, alarm_run: t[2] > 0,
    ready: cu_req.power && boot == 0};
endmodule // ppk_cu_model

/* tb_top.sv */
/*
  Bench of the paging panel key logic: presses keys, uses the register
  port and checks lamps, requests and registers.
  Assumes ppk_consts.svh on the include path; timing shortened.
*/
`timescale 1ns/1ps
`include "ppk_consts.svh"
module tb_top;
  import ppk_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  ppk_keys_t keys = '0;
  ppk_cu_stat_t cu_stat;
  ppk_cu_req_t cu_req;
  ppk_lamps_t lamps;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [4:0] disp_addr;
  logic [7:0] disp_char;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [49:0] busy_in = '0;
  logic preempt_in = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int skey [5] = '{`PPK_K_HALT, `PPK_K_MSG, `PPK_K_MSG, `PPK_K_MUSIC,
    `PPK_K_POWER};
  logic [31:0] sexp [5] = '{32'h001, 32'h000, 32'h0FF, 32'h100, 32'h0FF};

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  ppk_key_logic #(.DEB_CYC(4), .HOLD_CYC(50), .ASSIGN_CYC(100),
    .BLINK_CYC(4)) u_dut (.clock(clock), .rst(rst), .keys(keys),
    .cu_stat(cu_stat), .cu_req(cu_req), .lamps(lamps),
    .disp_addr(disp_addr), .disp_char(disp_char),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ppk_cu_model u_cu (.clock(clock), .rst(rst), .cu_req(cu_req),
    .cu_stat(cu_stat), .busy_in(busy_in), .preempt_in(preempt_in));

  // 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Data is read at the edge that closes its one-cycle slot
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_rdata & m, e);
  endtask

  // Held long enough to pass sync and debounce, then a quiet gap
  task automatic press(input int k, input int n);
    keys[k] <= 1'b1;
    repeat (n) @(posedge clock);
    keys[k] <= 1'b0;
    repeat (24) @(posedge clock);
  endtask

  // Lamp bit seen both lit and dark within sixteen cycles
  task automatic blink(input int b, input logic exp);
    logic s0;
    logic s1;
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (16)
    begin
      @(posedge clock);
      s0 |= !lamps[b];
      s1 |= lamps[b];
    end
    chk(s0 & s1, exp);
  endtask

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`PPK_REG_CTRL, 32'h3201, '1);
    wr(`PPK_REG_CTRL, 32'h3F01);
    rd(`PPK_REG_CTRL, 32'h3201, '1);
    rd(8'h9F, 32'h20, '1);
    wr(8'h80, 32'h41);
    rd(8'h80, 32'h41, '1);
    // Scan must come round to the first character within one pass
    for (int i = 0; i < 32 && disp_addr != 5'h00; i++)
      @(posedge clock);
    chk({disp_addr, disp_char}, {5'h00, 8'h41});
    rd(8'h40, 32'h0, '1);
    // Power up: lamp blinks while booting, then steady
    press(`PPK_K_POWER, 24);
    chk(cu_req.power, 1'b1);
    blink(2, 1'b1);
    repeat (200) @(posedge clock);
    blink(2, 1'b0);
    chk(lamps.power, 1'b1);
    press(`PPK_K_POWER, 30);
    chk(cu_req.power, 1'b1);
    // Selection toggles and every-area key
    press(0, 24);
    press(49, 24);
    rd(`PPK_REG_SEL_LO, 32'h1, '1);
    rd(`PPK_REG_SEL_HI, 32'h20000, '1);
    chk(lamps.area, 50'h2_0000_0000_0001);
    press(0, 24);
    chk(lamps.area, 50'h2_0000_0000_0000);
    press(`PPK_K_EVERY, 24);
    chk({lamps.area, lamps.every}, {50'h3_FFFF_FFFF_FFFF, 1'b1});
    press(`PPK_K_EVERY, 24);
    chk({lamps.area, lamps.every}, 51'h0);
    // Chime then message, each aborted by halt
    press(2, 24);
    for (int i = 0; i < 2; i++)
    begin
      press(`PPK_K_CHIME + i, 24);
      chk(lamps[5 - i], 1'b1);
      press(`PPK_K_HALT, 24);
      chk(lamps[5 - i], 1'b0);
    end
    // Alarm ended by a second press, then by halt
    press(`PPK_K_EMERG, 24);
    chk(lamps.alarm, 1'b1);
    press(`PPK_K_EMERG, 24);
    chk(lamps.alarm, 1'b0);
    press(`PPK_K_EMERG, 24);
    press(`PPK_K_HALT, 24);
    chk(lamps.alarm, 1'b0);
    // Speech lasts while held; preemption is not resumed
    for (int i = 0; i < 2; i++)
    begin
      keys.speak <= 1'b1;
      repeat (24) @(posedge clock);
      chk({cu_req.speak, lamps.busy}, 2'b11);
      preempt_in <= i[0];
      repeat (8) @(posedge clock);
      chk(cu_req.speak, !i[0]);
      blink(3, i[0]);
      preempt_in <= 1'b0;
      repeat (8) @(posedge clock);
      chk(cu_req.speak, !i[0]);
      keys.speak <= 1'b0;
      repeat (24) @(posedge clock);
      chk(cu_req.speak, 1'b0);
    end
    // Busy selected area refuses speech and flashes busy
    busy_in <= 50'h4;
    keys.speak <= 1'b1;
    repeat (24) @(posedge clock);
    chk(cu_req.speak, 1'b0);
    blink(3, 1'b1);
    keys.speak <= 1'b0;
    busy_in <= '0;
    repeat (24) @(posedge clock);
    // Program assign, timeout and exit by a function key
    press(`PPK_K_MUSIC, 24);
    rd(`PPK_REG_STATUS, 32'h2, 32'h7);
    press(5, 24);
    rd(`PPK_REG_MUS_LO, 32'h20, '1);
    chk({lamps.area, lamps.music}, {50'h20, 1'b1});
    chk(cu_req.music_areas, 50'h20);
    repeat (130) @(posedge clock);
    rd(`PPK_REG_STATUS, 32'h1, 32'h7);
    press(`PPK_K_MUSIC, 24);
    press(`PPK_K_CHIME, 24);
    rd(`PPK_REG_STATUS, 32'h1, 32'h7);
    chk(lamps.chime, 1'b0);
    // Setup entry, parameter moves and escape
    keys.music <= 1'b1;
    repeat (24) @(posedge clock);
    press(`PPK_K_HALT, 24);
    keys.music <= 1'b0;
    repeat (24) @(posedge clock);
    rd(`PPK_REG_STATUS, 32'h4, 32'h7);
    blink(1, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      press(skey[i], 24);
      rd(`PPK_REG_PARAM, sexp[i], 32'h7FF);
    end
    press(`PPK_K_CHIME, 24);
    rd(`PPK_REG_STATUS, 32'h1, 32'h7);
    wr(`PPK_REG_CTRL, 32'h3203);
    repeat (3) @(posedge clock);
    chk(cu_req.stop_any, 1'b1);
    // Long press powers down; disabled key is ignored
    wr(`PPK_REG_CTRL, 32'h3201);
    press(`PPK_K_POWER, 120);
    chk(cu_req.power, 1'b0);
    wr(`PPK_REG_CTRL, 32'h3200);
    press(`PPK_K_POWER, 24);
    chk(cu_req.power, 1'b0);
    test_done();
  end
endmodule // tb_top

bind ppk_key_logic ppk_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.clock(clock),
  .rst(rst), .keys(keys), .cu_stat(cu_stat), .cu_req(cu_req),
  .lamps(lamps), .disp_addr(disp_addr));
